// file: hdl/rsc_reset_ctrl.sv
`timescale 1ns/1ps
// ============================================================
`include "rsc_consts.svh"

module rsc_reset_ctrl #(
  parameter int STRETCH_C0 = `RSC_CYC(`RSC_STRETCH_US_0),
  parameter int STRETCH_C1 = `RSC_CYC(`RSC_STRETCH_US_1),
  parameter int STRETCH_C2 = `RSC_CYC(`RSC_STRETCH_US_2),
  parameter int STRETCH_C3 = `RSC_CYC(`RSC_STRETCH_US_3),
  parameter int CNT_W      = 21
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        supply_ok_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        low_supply_i,
  input  wire logic        wdog_timeout_i,
  input  wire logic        wdog_enable_i,
  input  wire logic        wdog_irq_mode_i,
  input  wire logic [2:0]  low_supply_level_fuse_i,
  input  wire logic [1:0]  startup_time_fuse_i,
  input  wire logic [3:0]  clock_select_fuse_i,
  output logic             io_rst_o,
  output logic             core_rst_o,
  output logic             fetch_start_o,
  output logic [2:0]       low_supply_level_o,
  output logic             irq_o,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  if (CNT_W < 2 || CNT_W > 31 || STRETCH_C3 >= (1 << CNT_W) || STRETCH_C0 < 1) begin : g_bad_cfg
    $error("rsc_reset_ctrl: stretch counts do not fit the counter");
  end

  // ============================================================
  // source synchronisers
  logic [1:0] por_s_r;
  logic [1:0] pin_s_r;
  logic [1:0] lowv_s_r;
  logic [1:0] wto_s_r;
  logic       wto_prev_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // idle levels, so sys_rst_i alone raises no cause event
      por_s_r  <= 2'h3;
      pin_s_r  <= 2'h3;
      lowv_s_r <= 2'h0;
      wto_s_r  <= 2'h0;
    end else begin
      por_s_r  <= {por_s_r[0], supply_ok_i};
      pin_s_r  <= {pin_s_r[0], reset_pin_n_i};
      lowv_s_r <= {lowv_s_r[0], low_supply_i};
      wto_s_r  <= {wto_s_r[0], wdog_timeout_i};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wto_prev_r <= 1'b0;
    end else begin
      wto_prev_r <= wto_s_r[1];
    end
  end

  // ============================================================
  // source combination
  logic lowv_en;
  logic async_src;
  logic por_act;
  logic pin_act;
  logic lowv_act;
  logic wdog_pulse;
  logic sync_src;

  assign lowv_en            = (low_supply_level_fuse_i != `RSC_LVL_OFF);
  assign low_supply_level_o = low_supply_level_fuse_i;

  assign async_src = !supply_ok_i || !reset_pin_n_i || (lowv_en && low_supply_i);

  assign por_act  = !por_s_r[1];
  assign pin_act  = !pin_s_r[1];
  assign lowv_act = lowv_en && lowv_s_r[1];
  assign wdog_pulse = wto_s_r[1] && !wto_prev_r && wdog_enable_i && !wdog_irq_mode_i;
  assign sync_src = por_act || pin_act || lowv_act || wdog_pulse;

  // ============================================================
  // delay counter
  function automatic logic [CNT_W-1:0] stretch_len(input logic [1:0] startup_time_fuse, input logic [3:0] cks);
    logic [1:0] sel;
    sel = startup_time_fuse ^ cks[1:0];
    case (sel)
      2'h0:    stretch_len = CNT_W'(STRETCH_C0);
      2'h1:    stretch_len = CNT_W'(STRETCH_C1);
      2'h2:    stretch_len = CNT_W'(STRETCH_C2);
      default: stretch_len = CNT_W'(STRETCH_C3);
    endcase
  endfunction

  rsc_pkg::rsc_state_t state_r;
  logic [CNT_W-1:0]    cnt_r;
  logic                fetch_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= rsc_pkg::RSC_ST_HOLD;
      cnt_r   <= '0;
    end else if (sync_src || async_src) begin
      state_r <= rsc_pkg::RSC_ST_HOLD;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        rsc_pkg::RSC_ST_HOLD: begin
          state_r <= rsc_pkg::RSC_ST_STRETCH;
          cnt_r   <= stretch_len(startup_time_fuse_i, clock_select_fuse_i);
        end
        rsc_pkg::RSC_ST_STRETCH: begin
          if (cnt_r <= CNT_W'(1)) begin
            state_r <= rsc_pkg::RSC_ST_RUN;
          end
          cnt_r <= cnt_r - CNT_W'(1);
        end
        rsc_pkg::RSC_ST_RUN: begin
          cnt_r <= '0;
        end
        default: begin
          state_r <= rsc_pkg::RSC_ST_HOLD;
        end
      endcase
    end
  end

  // fetch start pulses for one cycle, in the same cycle as release
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_r <= 1'b0;
    end else begin
      fetch_r <= (state_r == rsc_pkg::RSC_ST_STRETCH) && (cnt_r <= CNT_W'(1)) && !sync_src && !async_src;
    end
  end

  // I/O defaults held while reset active
  // io reset asserted without the clock, except for a watchdog timeout
  assign io_rst_o      = sys_rst_i || async_src || (state_r != rsc_pkg::RSC_ST_RUN);
  assign core_rst_o    = io_rst_o;
  assign fetch_start_o = fetch_r;

  // ============================================================
  // axi4-lite slave
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wdata_r;
  logic        wr_go;
  logic        rd_go;
  logic        bad_wr;

  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `RSC_ADDR_STATUS) || (a == `RSC_ADDR_IRQ_STAT) ||
                 (a == `RSC_ADDR_IRQ_MASK) || (a == `RSC_ADDR_CTRL);
  endfunction

  assign bad_wr = !addr_known(awaddr_r);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_ok_r  <= 1'b0;
      w_ok_r   <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_ok_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r  <= 1'b1;
        // narrow registers: only byte lane 0 matters
        wdata_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'hff;
      end else if (wr_go) begin
        w_ok_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= bad_wr ? `RSC_RESP_SLVERR : `RSC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ============================================================
  // cause flags and interrupt
  rsc_pkg::rsc_cause_t cause_r;
  rsc_pkg::rsc_cause_t ev;
  logic [3:0]          irq_st_r;
  logic [3:0]          irq_mask_r;
  logic                clr_cause;
  logic                clr_irq;
  logic [3:0]          ev_bits;

  assign ev.por   = por_act;
  assign ev.pin   = pin_act;
  assign ev.lowv  = lowv_act;
  assign ev.wdog  = wdog_pulse;
  assign ev_bits  = ev;
  assign clr_cause = wr_go && (awaddr_r == `RSC_ADDR_STATUS);
  assign clr_irq   = wr_go && (awaddr_r == `RSC_ADDR_IRQ_STAT);

  // cause flags survive sys_rst_i; only supply loss or a written zero clears them, and supply loss sets por
  // watchdog flag, cleared by powerup or zero
  // low supply flag, cleared by powerup or zero
  // pin flag, cleared by powerup or zero
  // powerup flag cleared only by zero
  always_ff @(posedge clk_i) begin
    if (ev.por) begin
      cause_r <= '{wdog: 1'b0, lowv: 1'b0, pin: 1'b0, por: 1'b1};
    end else begin
      cause_r.wdog <= ev.wdog || (cause_r.wdog && !(clr_cause && !wdata_r[`RSC_BIT_WDOG]));
      cause_r.lowv <= ev.lowv || (cause_r.lowv && !(clr_cause && !wdata_r[`RSC_BIT_LOWV]));
      cause_r.pin  <= ev.pin || (cause_r.pin && !(clr_cause && !wdata_r[`RSC_BIT_PIN]));
      cause_r.por  <= cause_r.por && !(clr_cause && !wdata_r[`RSC_BIT_POR]);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_st_r <= 4'h0;
    end else begin
      irq_st_r <= ev_bits | (irq_st_r & ~(clr_irq ? wdata_r[3:0] : 4'h0));
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask_r <= 4'h0;
    end else if (wr_go && awaddr_r == `RSC_ADDR_IRQ_MASK) begin
      irq_mask_r <= wdata_r[3:0];
    end
  end

  assign irq_o = |(irq_st_r & irq_mask_r);

  // ============================================================
  // read path
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RSC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RSC_RESP_OKAY;
      case (s_axi_araddr[7:0])
        `RSC_ADDR_STATUS:   s_axi_rdata <= {28'h0, cause_r};
        `RSC_ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, irq_st_r};
        `RSC_ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_r};
        `RSC_ADDR_CTRL:     s_axi_rdata <= {24'h0, 1'b0, low_supply_level_fuse_i, 2'h0, state_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rsc_reset_ctrl

// file: inc/rsc_consts.svh
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
// register byte addresses
`define RSC_ADDR_STATUS    8'h00
`define RSC_ADDR_IRQ_STAT  8'h04
`define RSC_ADDR_IRQ_MASK  8'h08
`define RSC_ADDR_CTRL      8'h0c
// status bit positions
`define RSC_BIT_POR        0
`define RSC_BIT_PIN        1
`define RSC_BIT_LOWV       2
`define RSC_BIT_WDOG       3
// low supply level fuse codes
`define RSC_LVL_OFF        3'b111
`define RSC_LVL_1          3'b110
`define RSC_LVL_2          3'b101
`define RSC_LVL_3          3'b100
// stretch period per startup fuse code xor clock select bits 1:0, in microseconds
`define RSC_STRETCH_US_0   32'd4
`define RSC_STRETCH_US_1   32'd64
`define RSC_STRETCH_US_2   32'd4100
`define RSC_STRETCH_US_3   32'd65000
`define RSC_CLK_MHZ        32'd25
`define RSC_CYC(us)        ((us) * `RSC_CLK_MHZ)
// axi responses
`define RSC_RESP_OKAY      2'b00
`define RSC_RESP_SLVERR    2'b10
`endif

// file: inc/rsc_pkg.sv
package rsc_pkg;
  typedef struct packed {
    logic       wdog;
    logic       lowv;
    logic       pin;
    logic       por;
  } rsc_cause_t;
  typedef enum logic [1:0] {
    RSC_ST_HOLD,
    RSC_ST_STRETCH,
    RSC_ST_RUN
  } rsc_state_t;
endpackage

// file: verification/rsc_props.sv
`timescale 1ns/1ps
module rsc_props #(
  parameter int STRETCH_C0 = 4
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       supply_ok_i,
  input wire logic       reset_pin_n_i,
  input wire logic       low_supply_i,
  input wire logic       wdog_timeout_i,
  input wire logic       wdog_enable_i,
  input wire logic       wdog_irq_mode_i,
  input wire logic [2:0] low_supply_level_fuse_i,
  input wire logic       io_rst_o,
  input wire logic       core_rst_o,
  input wire logic       fetch_start_o
);
  logic        src_act;
  logic [15:0] idle_cnt_r;
  // ==========
  // helper: cycles since a source or a reset rise
  assign src_act = !reset_pin_n_i || !supply_ok_i || (low_supply_i && low_supply_level_fuse_i != 3'b111);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_cnt_r <= 16'h0000;
    end else if (src_act || $rose(io_rst_o)) begin
      idle_cnt_r <= 16'h0000;
    end else if (idle_cnt_r != 16'hffff) begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========
  // assertions
  pin_hold_a: assert property (!reset_pin_n_i |-> io_rst_o)
    else $error("pin low but no reset");
  supply_hold_a: assert property (!supply_ok_i |-> io_rst_o)
    else $error("supply low but no reset");
  lowv_hold_a: assert property (low_supply_i && low_supply_level_fuse_i != 3'b111 |-> io_rst_o)
    else $error("low supply but no reset");
  stretch_len_a: assert property ($fell(io_rst_o) |-> idle_cnt_r >= 16'(STRETCH_C0))
    else $error("reset released too early");
  pin_release_a: assert property ($rose(reset_pin_n_i) |-> io_rst_o [*4])
    else $error("no stretch after pin release");
  wdog_rst_a: assert property ($rose(wdog_timeout_i) && wdog_enable_i && !wdog_irq_mode_i |-> ##[1:6] io_rst_o)
    else $error("watchdog reset missing");
  wdog_quiet_a: assert property (!io_rst_o && !src_act && wdog_irq_mode_i && $rose(wdog_timeout_i) |-> !io_rst_o [*6])
    else $error("watchdog reset in interrupt mode");
  fetch_pulse_a: assert property ($fell(io_rst_o) |-> ##[0:1] fetch_start_o ##1 !fetch_start_o)
    else $error("fetch start pulse wrong");
  core_same_a: assert property (core_rst_o == io_rst_o)
    else $error("core and io reset differ");
endmodule // rsc_props

bind rsc_reset_ctrl rsc_props #(.STRETCH_C0(STRETCH_C0)) u_rsc_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i), .reset_pin_n_i(reset_pin_n_i),
  .low_supply_i(low_supply_i), .wdog_timeout_i(wdog_timeout_i), .wdog_enable_i(wdog_enable_i),
  .wdog_irq_mode_i(wdog_irq_mode_i), .low_supply_level_fuse_i(low_supply_level_fuse_i),
  .io_rst_o(io_rst_o), .core_rst_o(core_rst_o), .fetch_start_o(fetch_start_o)
);

// file: verification/rsc_src_model.sv
`timescale 1ns/1ps
module rsc_src_model #(
  // cycles a source is held: past 2.5 us at 25 MHz
  parameter int PIN_MIN = 63
) (
  input  wire logic clk_i,
  output logic      supply_ok_o,
  output logic      reset_pin_n_o,
  output logic      low_supply_o,
  output logic      wdog_timeout_o
);
  // ==========
  // supply starts low, so power-up is the first event
  initial begin
    supply_ok_o    = 1'b0;
    reset_pin_n_o  = 1'b1;
    low_supply_o   = 1'b0;
    wdog_timeout_o = 1'b0;
  end
  // kind 0 pin, 1 low supply, 2 watchdog expiry, 3 supply dip
  // pin held past min width
  task automatic event_go(input int kind);
    @(posedge clk_i);
    reset_pin_n_o  <= (kind != 0);
    low_supply_o   <= (kind == 1);
    wdog_timeout_o <= (kind == 2);
    supply_ok_o    <= (kind != 3);
    repeat (PIN_MIN) @(posedge clk_i);
    reset_pin_n_o  <= 1'b1;
    low_supply_o   <= 1'b0;
    wdog_timeout_o <= 1'b0;
    supply_ok_o    <= 1'b1;
  endtask
endmodule // rsc_src_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "rsc_consts.svh"
module tb_top;
  typedef struct {int kind; logic [2:0] fuse; logic [1:0] wd; logic [1:0] startup_time_fuse; logic [3:0] cks;
                  logic [3:0] flags; bit rst;} rsc_row_t;
  localparam int STR [4] = '{4, 8, 16, 32};
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, sup, pin_n, lowv, wdt, wen, wirq;
  logic        io_rst_o, core_rst_o, fetch_o, irq_o, awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
  logic [2:0]  fuse, lvl_o;
  logic [1:0]  startup_time_fuse, bresp, rresp, r;
  logic [3:0]  cks, strb;
  logic [31:0] awa, wd, ara, rd, d;
  int          miscompares = 0, n_checks = 0, cyc, n;
  bit          rst_seen;
  rsc_row_t    rows [11] = '{'{0,3'b110,0,2'd0,4'h0,4'h2,1}, '{0,3'b110,0,2'd1,4'h0,4'h2,1},
    '{0,3'b110,0,2'd1,4'h3,4'h2,1}, '{0,3'b110,0,2'd3,4'h0,4'h2,1}, '{1,3'b110,0,2'd0,4'h0,4'h4,1},
    '{1,3'b101,0,2'd0,4'h0,4'h4,1}, '{1,3'b100,0,2'd0,4'h0,4'h4,1}, '{1,3'b111,0,2'd0,4'h0,4'h0,0},
    '{2,3'b110,2,2'd0,4'h0,4'h8,1}, '{2,3'b110,3,2'd0,4'h0,4'h0,0}, '{2,3'b110,0,2'd0,4'h0,4'h0,0}};
  always #20 clk_i = ~clk_i;
  always @(negedge clk_i) if (io_rst_o === 1'b1) rst_seen = 1'b1;
  initial begin
    {awv, wv, bry, arv, rry, awa, wd, ara} = '0;
    {wen, wirq, startup_time_fuse, cks} = '0;
    fuse = 3'b110;
    strb = 4'hf;
  end
  rsc_src_model src (.clk_i(clk_i), .supply_ok_o(sup), .reset_pin_n_o(pin_n), .low_supply_o(lowv),
                     .wdog_timeout_o(wdt));
  rsc_reset_ctrl #(.STRETCH_C0(4), .STRETCH_C1(8), .STRETCH_C2(16), .STRETCH_C3(32)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(sup), .reset_pin_n_i(pin_n), .low_supply_i(lowv),
    .wdog_timeout_i(wdt), .wdog_enable_i(wen), .wdog_irq_mode_i(wirq), .low_supply_level_fuse_i(fuse),
    .startup_time_fuse_i(startup_time_fuse), .clock_select_fuse_i(cks), .io_rst_o(io_rst_o), .core_rst_o(core_rst_o),
    .fetch_start_o(fetch_o), .low_supply_level_o(lvl_o), .irq_o(irq_o), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  // ==========
  // checking and closing
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hung();
    miscompares++;
    results();
  endtask
  // ==========
  // bus master: valids held until taken, ready held until answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit aw, w, b;
    int k;
    @(posedge clk_i);
    awa <= {24'h0, a};
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    b = 1'b0;
    for (k = 0; k < 50 && !b; k++) begin
      @(negedge clk_i);
      aw = awv && awr;
      w = wv && wr;
      b = bv && bry;
      r = bresp;
      @(posedge clk_i);
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
      if (b) bry <= 1'b0;
    end
    if (!b) hung();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    bit ar, b;
    int k;
    @(posedge clk_i);
    ara <= {24'h0, a};
    arv <= 1'b1;
    rry <= 1'b1;
    b = 1'b0;
    for (k = 0; k < 50 && !b; k++) begin
      @(negedge clk_i);
      ar = arv && arr;
      b = rv && rry;
      d = rd;
      r = rresp;
      @(posedge clk_i);
      if (ar) arv <= 1'b0;
      if (b) rry <= 1'b0;
    end
    if (!b) hung();
  endtask
  task automatic settle();
    @(negedge clk_i);
    for (cyc = 0; cyc < 400 && io_rst_o !== 1'b0; cyc++) @(negedge clk_i);
    if (cyc == 400) hung();
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    src.event_go(3);
    settle();
    axi_rd(`RSC_ADDR_STATUS);
    chk_word("powerup_flag", 32'h1, d);
    foreach (rows[i]) begin
      axi_wr(`RSC_ADDR_STATUS, 32'h0);
      @(posedge clk_i);
      fuse <= rows[i].fuse;
      {wen, wirq} <= rows[i].wd;
      startup_time_fuse <= rows[i].startup_time_fuse;
      cks <= rows[i].cks;
      rst_seen = 1'b0;
      src.event_go(rows[i].kind);
      settle();
      n = STR[rows[i].startup_time_fuse ^ rows[i].cks[1:0]];
      chk_flag("stretch", 1'b1, rows[i].rst ? rst_seen && cyc <= n + 8 && (rows[i].kind == 2 || cyc >= n) : !rst_seen);
      axi_rd(`RSC_ADDR_STATUS);
      chk_word("cause_status", {28'h0, rows[i].flags}, d);
    end
    axi_wr(`RSC_ADDR_STATUS, 32'h0);
    axi_wr(`RSC_ADDR_IRQ_STAT, 32'hf);
    fork
      src.event_go(0);
      begin
        @(posedge clk_i);
        #2;
        chk_flag("io_rst_async", 1'b1, io_rst_o);
      end
    join
    settle();
    axi_wr(`RSC_ADDR_STATUS, 32'hf);
    axi_rd(`RSC_ADDR_STATUS);
    chk_word("ones_ignored", 32'h2, d);
    @(posedge clk_i);
    strb <= 4'he;
    axi_wr(`RSC_ADDR_STATUS, 32'h0);
    strb <= 4'hf;
    axi_rd(`RSC_ADDR_STATUS);
    chk_word("lane0_off", 32'h2, d);
    axi_rd(`RSC_ADDR_IRQ_STAT);
    chk_word("irq_status", 32'h2, d);
    axi_wr(`RSC_ADDR_IRQ_MASK, 32'h2);
    chk_flag("irq_on", 1'b1, irq_o);
    axi_wr(`RSC_ADDR_IRQ_MASK, 32'h0);
    chk_flag("irq_masked", 1'b0, irq_o);
    axi_wr(`RSC_ADDR_IRQ_MASK, 32'h2);
    axi_wr(`RSC_ADDR_IRQ_STAT, 32'h2);
    chk_flag("irq_cleared", 1'b0, irq_o);
    // mid-run system reset: outputs held, cause flags kept
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_flag("io_rst_in_reset", 1'b1, io_rst_o);
    chk_flag("bvalid_in_reset", 1'b0, bv);
    sys_rst_i <= 1'b0;
    settle();
    axi_rd(`RSC_ADDR_STATUS);
    chk_word("flags_kept", 32'h2, d);
    src.event_go(3);
    settle();
    axi_rd(`RSC_ADDR_STATUS);
    chk_word("powerup_clears", 32'h1, d);
    axi_rd(8'h10);
    chk_word("unmapped_rd", {30'h0, `RSC_RESP_SLVERR}, {rd[29:0], r});
    axi_wr(8'h14, 32'h0);
    chk_word("unmapped_wr", {30'h0, `RSC_RESP_SLVERR}, {30'h0, r});
    axi_rd(`RSC_ADDR_CTRL);
    chk_word("ctrl", {25'h0, 3'b110, 2'b00, 2'(rsc_pkg::RSC_ST_RUN)}, d);
    chk_word("level_out", 32'h6, {29'h0, lvl_o});
    results();
  end
endmodule // tb_top
